// >>> hdl/cptm_pkg.sv
// Summary of operation
// - Send periodically, period 0..65000 ms; zero disables sending and is the default.
// - Three-bit priority 0..7 in identifier bits, default six.
// - Group number limited to 0xFF00..0xFFFF broadcast proprietary range.
// - Destination address default 255, used only for destination-specific formats.
// - Four independent signals, each from a selectable category and instance.
// - Starting byte 0..7 per signal, default first byte.
// - Starting bit 0..7 within that byte, default zero; signals may share bytes.
// - Field width chosen from a fixed size list, default sixteen bits.
// - Offset limited to plus or minus ten thousand; resolution per bit.
// - Minimum and maximum bound the sent value; minimum defaults to zero.
// - Selectable signal type, default type 2 continuous numeric data.
package cptm_pkg;
  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int NSIG = 4;
  localparam int NCAT = 8;
  localparam int NINST = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [5:0] DIV_LAST = 6'h20;
  // ****************************************
  // Field values and defaults
  // ****************************************
  localparam logic [15:0] PERIOD_MAX = 16'hFDE8;
  localparam logic [15:0] PERIOD_DFLT = 16'h0000;
  localparam logic [2:0] PRIO_DFLT = 3'h6;
  localparam logic [7:0] PGN_PAGE = 8'hFF;
  localparam logic [7:0] PDU2_MIN = 8'hF0;
  localparam logic [7:0] GE_DFLT = 8'h00;
  localparam logic [7:0] DA_DFLT = 8'hFF;
  localparam logic [7:0] SA_DFLT = 8'h80;
  localparam logic [1:0] TYPE_OFF = 2'h0;
  localparam logic [1:0] TYPE_CONT = 2'h2;
  localparam logic [2:0] SIZE_DFLT = 3'h5;
  localparam logic signed [31:0] OFFS_LIM = 32'h0098_9680;
  localparam logic signed [31:0] RES_DFLT = 32'h0000_03E8;
  localparam logic signed [31:0] MAX_DFLT = 32'h7FFF_FFFF;
  localparam logic [63:0] PAYLOAD_FILL = 64'hFFFF_FFFF_FFFF_FFFF;
  // ****************************************
  // Types
  // ****************************************
  typedef logic [NCAT-1:0][NINST-1:0][31:0] cptm_src_t;
  typedef struct packed {
    logic [2:0] cat;
    logic [1:0] inst;
    logic [1:0] sigType;
    logic [2:0] bytePos;
    logic [2:0] bitPos;
    logic [2:0] sizeCode;
    logic signed [31:0] resolution;
    logic signed [31:0] offset;
    logic signed [31:0] minVal;
    logic signed [31:0] maxVal;
  } cptm_sig_t;
  typedef struct packed {
    logic [15:0] period;
    logic [2:0] prio;
    logic [7:0] pgnLow;
    logic [7:0] destAddr;
    logic [7:0] srcAddr;
    cptm_sig_t [NSIG-1:0] sig;
  } cptm_cfg_t;
  typedef struct packed {
    logic [28:0] id;
    logic [63:0] data;
  } cptm_frame_t;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_PACK, ST_PUSH} cptm_state_t;
  localparam cptm_sig_t SIG_DFLT = '{cat: 3'h0, inst: 2'h0, sigType: TYPE_CONT, bytePos: 3'h0,
    bitPos: 3'h0, sizeCode: SIZE_DFLT, resolution: RES_DFLT, offset: 32'h0, minVal: 32'h0, maxVal: MAX_DFLT};
  localparam cptm_cfg_t CFG_DFLT = '{period: PERIOD_DFLT, prio: PRIO_DFLT, pgnLow: GE_DFLT,
    destAddr: DA_DFLT, srcAddr: SA_DFLT, sig: {NSIG{SIG_DFLT}}};
  // Field mask for each size code
  function automatic logic [31:0] sizeMask(input logic [2:0] code);
    case (code)
      3'h0: sizeMask = 32'h0000_0001;
      3'h1: sizeMask = 32'h0000_0003;
      3'h2: sizeMask = 32'h0000_000F;
      3'h3: sizeMask = 32'h0000_00FF;
      3'h4: sizeMask = 32'h0000_0FFF;
      3'h5: sizeMask = 32'h0000_FFFF;
      3'h6: sizeMask = 32'h00FF_FFFF;
      default: sizeMask = 32'hFFFF_FFFF;
    endcase
  endfunction
endpackage

// >>> hdl/cptm_packer.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Frame FIFO
// ****************************************
module cptm_fifo
  import cptm_pkg::*;
#(
  parameter int WIDTH = 93,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_r;
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doWrite;
  logic doRead;
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (doRead)
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem_r[wrPtr_r] <= inData;
  end
endmodule // cptm_fifo

// ****************************************
// Periodic message packer
// ****************************************
module cptm_packer
  import cptm_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgWrite,
  input wire cptm_cfg_t cfgIn,
  input wire cptm_src_t srcValues,
  output cptm_frame_t txFrame,
  output logic txValid,
  input wire logic txReady,
  output logic busy
);
  localparam int TW = $clog2(TICK_DIV);
  cptm_cfg_t cfg_r;
  cptm_cfg_t cfgSat;
  logic [TW-1:0] tickCnt_r;
  logic tick_r;
  logic [15:0] msCnt_r;
  logic trig;
  logic pend_r;
  cptm_state_t state_r;
  logic [1:0] sigIdx_r;
  logic [63:0] payload_r;
  logic [32:0] quo_r;
  logic [32:0] rem_r;
  logic [31:0] den_r;
  logic neg_r;
  logic [5:0] step_r;
  cptm_frame_t txFrame_r;
  logic txValid_r;
  logic busy_r;
  // ****************************************
  // Configuration capture
  // ****************************************
  always_comb
  begin
    cfgSat = cfgIn;
    if (cfgIn.period > PERIOD_MAX)
      cfgSat.period = PERIOD_MAX;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cfg_r <= CFG_DFLT;
    else if (cfgWrite)
      cfg_r <= cfgSat;
  end
  // ****************************************
  // Millisecond tick and period timer
  // ****************************************
  logic tickEnd;
  logic periodEnd;
  assign tickEnd = (tickCnt_r == TW'(TICK_DIV-1));
  assign periodEnd = ((msCnt_r + 16'h1) >= cfg_r.period);
  assign trig = tick_r && (cfg_r.period != PERIOD_DFLT) && periodEnd;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_r <= '0;
      tick_r <= 1'b0;
      msCnt_r <= '0;
    end
    else
    begin
      tickCnt_r <= tickEnd ? '0 : tickCnt_r + 1'b1;
      tick_r <= tickEnd;
      if (cfgWrite || cfg_r.period == PERIOD_DFLT)
        msCnt_r <= '0;
      else if (tick_r)
        msCnt_r <= periodEnd ? '0 : msCnt_r + 16'h1;
    end
  end
  // ****************************************
  // Signal conversion
  // ****************************************
  cptm_sig_t curSig;
  logic signed [31:0] srcVal;
  logic signed [31:0] clamped;
  logic signed [31:0] offLim;
  logic signed [32:0] diff;
  logic [32:0] absDiff;
  logic [31:0] absRes;
  logic [32:0] remSh;
  logic remGe;
  logic [32:0] sres;
  logic [31:0] field;
  logic [31:0] fieldMask;
  logic [5:0] pos;
  logic [63:0] mask64;
  logic [63:0] payloadNxt;
  logic lastSig;
  assign curSig = cfg_r.sig[sigIdx_r];
  assign srcVal = $signed(srcValues[curSig.cat][curSig.inst]);
  assign clamped = ($signed(srcVal) > $signed(curSig.maxVal)) ? curSig.maxVal :
    ($signed(srcVal) < $signed(curSig.minVal)) ? curSig.minVal : srcVal;
  assign offLim = ($signed(curSig.offset) > OFFS_LIM) ? OFFS_LIM :
    ($signed(curSig.offset) < -OFFS_LIM) ? -OFFS_LIM : curSig.offset;
  assign diff = {clamped[31], clamped} - {offLim[31], offLim};
  assign absDiff = diff[32] ? 33'(-diff) : diff;
  assign absRes = curSig.resolution[31] ? 32'(-curSig.resolution) : curSig.resolution;
  assign remSh = {rem_r[31:0], quo_r[32]};
  assign remGe = (remSh >= {1'b0, den_r});
  assign sres = neg_r ? 33'(-quo_r) : quo_r;
  assign fieldMask = sizeMask(curSig.sizeCode);
  assign field = sres[31:0] & fieldMask;
  assign pos = {curSig.bytePos, curSig.bitPos};
  assign mask64 = {32'h0, fieldMask} << pos;
  assign payloadNxt = (payload_r & ~mask64) | ({32'h0, field} << pos);
  assign lastSig = (sigIdx_r == 2'(NSIG-1));
  // ****************************************
  // Identifier
  // ****************************************
  logic [7:0] pduSpec;
  cptm_frame_t frameNxt;
  assign pduSpec = (PGN_PAGE < PDU2_MIN) ? cfg_r.destAddr : cfg_r.pgnLow;
  assign frameNxt = '{id: {cfg_r.prio, 2'b00, PGN_PAGE, pduSpec, cfg_r.srcAddr}, data: payload_r};
  // ****************************************
  // Sequencer
  // ****************************************
  logic fifoInReady;
  logic fifoOutValid;
  cptm_frame_t fifoOut;
  logic fifoOutReady;
  logic pushReq;
  assign pushReq = (state_r == ST_PUSH);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_r <= 1'b0;
    else
      pend_r <= trig || (pend_r && state_r != ST_IDLE);
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      sigIdx_r <= '0;
      payload_r <= PAYLOAD_FILL;
      quo_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      neg_r <= 1'b0;
      step_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (pend_r)
          begin
            sigIdx_r <= '0;
            payload_r <= PAYLOAD_FILL;
            state_r <= ST_LOAD;
          end
        ST_LOAD:
          if (curSig.sigType == TYPE_OFF)
          begin
            sigIdx_r <= sigIdx_r + 2'h1;
            state_r <= lastSig ? ST_PUSH : ST_LOAD;
          end
          else
          begin
            quo_r <= absDiff;
            rem_r <= '0;
            den_r <= absRes;
            neg_r <= diff[32] ^ curSig.resolution[31];
            step_r <= '0;
            state_r <= ST_DIV;
          end
        ST_DIV:
        begin
          rem_r <= remGe ? 33'(remSh - {1'b0, den_r}) : remSh;
          quo_r <= {quo_r[31:0], remGe};
          step_r <= step_r + 6'h1;
          if (step_r == DIV_LAST)
            state_r <= ST_PACK;
        end
        ST_PACK:
        begin
          payload_r <= payloadNxt;
          sigIdx_r <= sigIdx_r + 2'h1;
          state_r <= lastSig ? ST_PUSH : ST_LOAD;
        end
        ST_PUSH:
          if (fifoInReady)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
  // ****************************************
  // Buffer and output stage
  // ****************************************
  cptm_fifo #(.WIDTH($bits(cptm_frame_t)), .DEPTH(FIFO_DEPTH)) u_cptm_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(pushReq),
    .inReady(fifoInReady),
    .inData(frameNxt),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );
  assign fifoOutReady = !txValid_r || txReady;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txValid_r <= 1'b0;
      txFrame_r <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      if (fifoOutReady)
        txValid_r <= fifoOutValid;
      if (fifoOutReady && fifoOutValid)
        txFrame_r <= fifoOut;
      busy_r <= (state_r != ST_IDLE) || pend_r;
    end
  end
  assign txFrame = txFrame_r;
  assign txValid = txValid_r;
  assign busy = busy_r;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_zero_period_quiet: assert property (cfg_r.period == PERIOD_DFLT && state_r == ST_IDLE && !pend_r
    |=> state_r == ST_IDLE) else $error("transmit started with zero period");
  a_period_cap: assert property (cfg_r.period <= PERIOD_MAX) else $error("period above limit");
  a_prio_field: assert property (state_r == ST_PUSH |-> frameNxt.id[28:26] == cfg_r.prio)
    else $error("priority not in identifier");
  a_pgn_page: assert property (state_r == ST_PUSH |-> frameNxt.id[25:16] == {2'b00, PGN_PAGE})
    else $error("group number outside proprietary range");
  a_dest_ignored: assert property (state_r == ST_PUSH |-> frameNxt.id[15:8] == cfg_r.pgnLow)
    else $error("destination used in broadcast format");
  a_source_addr: assert property (state_r == ST_PUSH |-> frameNxt.id[7:0] == cfg_r.srcAddr)
    else $error("source address missing");
  a_offset_limit: assert property (state_r == ST_LOAD |-> offLim <= OFFS_LIM && offLim >= -OFFS_LIM)
    else $error("offset beyond limit");
  a_clamp_bounds: assert property (state_r == ST_LOAD && $signed(curSig.minVal) <= $signed(curSig.maxVal)
    |-> $signed(clamped) >= $signed(curSig.minVal) && $signed(clamped) <= $signed(curSig.maxVal))
    else $error("value not clamped");
  a_div_length: assert property ($rose(state_r == ST_DIV) |-> ##32 state_r == ST_DIV ##1 state_r == ST_PACK)
    else $error("divide length wrong");
  a_pack_field: assert property (state_r == ST_PACK |=> ((payload_r >> $past(pos)) &
    {32'h0, $past(fieldMask)}) == (({32'h0, $past(field)} << $past(pos)) >> $past(pos)))
    else $error("field not packed");
  c_trigger: cover property (trig);
  c_push_stall: cover property (state_r == ST_PUSH && !fifoInReady);
  c_frame_taken: cover property (txValid && txReady);
  c_signal_off: cover property (state_r == ST_LOAD && curSig.sigType == TYPE_OFF);
endmodule // cptm_packer
`default_nettype wire

// >>> tb/cptm_can_sink.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Receiving controller model
// ****************************************
module cptm_can_sink
  import cptm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic slow,
  input wire cptm_frame_t txFrame,
  input wire logic txValid,
  output logic txReady,
  output cptm_frame_t gotFrame,
  output int gotCnt,
  output int accCyc
);
  int cyc;
  // Held means never ready; slow accepts one cycle in four
  assign txReady = !hold && (!slow || cyc[1:0] == 2'h0);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cyc <= 0;
      gotCnt <= 0;
      accCyc <= 0;
      gotFrame <= '0;
    end
    else
    begin
      cyc <= cyc + 1;
      if (txValid && txReady)
      begin
        gotFrame <= txFrame;
        gotCnt <= gotCnt + 1;
        accCyc <= cyc;
      end
    end
  end
endmodule // cptm_can_sink
`default_nettype wire

// >>> tb/cptm_packer_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Packer testbench
// ****************************************
module cptm_packer_tb
  import cptm_pkg::*;
;
  localparam int TDIV = 10;
  localparam int LIMIT = 12000;
  logic clk, rst, cfgWrite, txValid, txReady, busy, hold, slow;
  cptm_cfg_t cfg, nc;
  cptm_src_t src;
  cptm_frame_t txFrame, gotFrame;
  int gotCnt, accCyc, nMismatch, cmpCount, cycles, t0;
  logic [28:0] expId;
  logic [63:0] expData;

  cptm_packer #(.TICK_DIV(TDIV)) u_cptm_packer (.clk(clk), .rst(rst), .cfgWrite(cfgWrite), .cfgIn(cfg),
    .srcValues(src), .txFrame(txFrame), .txValid(txValid), .txReady(txReady), .busy(busy));
  cptm_can_sink u_cptm_can_sink (.clk(clk), .rst(rst), .hold(hold), .slow(slow), .txFrame(txFrame),
    .txValid(txValid), .txReady(txReady), .gotFrame(gotFrame), .gotCnt(gotCnt), .accCyc(accCyc));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      nMismatch = nMismatch + 1;
      closeOut();
    end
  end

  task automatic chk(input logic [92:0] seen, input logic [92:0] exp);
    cmpCount = cmpCount + 1;
    if (seen !== exp)
    begin
      nMismatch = nMismatch + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic closeOut();
    $display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic writeCfg(input cptm_cfg_t c);
    @(posedge clk);
    #1 cfg = c;
    cfgWrite = 1'b1;
    @(posedge clk);
    #1 cfgWrite = 1'b0;
  endtask

  task automatic setSig(input int i, input logic [2:0] ca, input logic [1:0] ins, input logic [1:0] ty,
    input logic [2:0] by, input logic [2:0] bi, input logic [2:0] sz, input logic [31:0] re, input logic [31:0] of,
    input logic [31:0] mn, input logic [31:0] mx);
    nc.sig[i] = '{cat: ca, inst: ins, sigType: ty, bytePos: by, bitPos: bi, sizeCode: sz, resolution: re,
      offset: of, minVal: mn, maxVal: mx};
  endtask

  // Waits for the next accepted frame and compares it
  task automatic waitFrame();
    int n;
    int k;
    n = gotCnt;
    k = 0;
    while (gotCnt == n && k < 800)
    begin
      @(posedge clk);
      #2 k = k + 1;
    end
    chk(93'(gotCnt), 93'(n + 1));
    chk({gotFrame.id, gotFrame.data}, {expId, expData});
  endtask

  function automatic logic [63:0] put(input logic [63:0] d, input int pos, input int w, input logic [31:0] v);
    for (int i = 0; i < w; i++)
      if (pos + i < 64)
        d[pos + i] = v[i];
    return d;
  endfunction

  initial
  begin
    rst = 1'b1;
    cfgWrite = 1'b0;
    cfg = CFG_DFLT;
    src = '0;
    hold = 1'b0;
    slow = 1'b0;
    nMismatch = 0;
    cmpCount = 0;
    cycles = 0;
    src[0][0] = 32'h000B_DB28;
    src[1][2] = 32'h0012_D450;
    src[2][0] = 32'h0000_61A8;
    src[4][1] = 32'h0000_4E20;
    src[7][3] = -32'h0000_1388;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    // ****************************************
    // Default period sends nothing
    // ****************************************
    repeat (300) @(posedge clk);
    #1 chk(93'(gotCnt), 93'h0);
    chk(93'(txValid), 93'h0);
    // ****************************************
    // Defaults, stalled receiver, merged triggers
    // ****************************************
    nc = CFG_DFLT;
    nc.period = 16'h0001;
    expId = {PRIO_DFLT, 2'h0, 8'hFF, 8'h00, 8'h80};
    expData = put(PAYLOAD_FILL, 0, 16, 32'h0000_0309);
    hold = 1'b1;
    writeCfg(nc);
    repeat (1500) @(posedge clk);
    #1 chk({91'h0, busy, txValid}, 93'h3);
    hold = 1'b0;
    slow = 1'b1;
    repeat (5) waitFrame();
    // ****************************************
    // Period zero stops sending
    // ****************************************
    nc.period = 16'h0000;
    writeCfg(nc);
    repeat (1000) @(posedge clk);
    #1 t0 = gotCnt;
    repeat (600) @(posedge clk);
    #1 chk(93'(gotCnt), 93'(t0));
    chk(93'(txValid), 93'h0);
    // ****************************************
    // Four configured signals, offset limit, clamps
    // ****************************************
    slow = 1'b0;
    nc = '{period: 16'h0014, prio: 3'h3, pgnLow: 8'h80, destAddr: 8'h12, srcAddr: 8'h55, sig: '0};
    setSig(0, 3'h1, 2'h2, 2'h3, 3'h0, 3'h0, 3'h5, 32'h3E8, 32'h0, 32'h0, 32'h006A_CFC0);
    setSig(1, 3'h2, 2'h0, 2'h1, 3'h3, 3'h0, 3'h3, 32'h3E8, -32'h0131_2D00, -32'h9C40, 32'h0002_49F0);
    setSig(2, 3'h4, 2'h1, 2'h2, 3'h4, 3'h4, 3'h2, 32'h7D, 32'h0, 32'h0, 32'h3E8);
    setSig(3, 3'h7, 2'h3, 2'h2, 3'h7, 3'h4, 3'h5, 32'h3E8, 32'h0, 32'h0, MAX_DFLT);
    expId = {3'h3, 2'h0, 8'hFF, 8'h80, 8'h55};
    expData = put(put(put(PAYLOAD_FILL, 0, 16, 32'h4D2), 24, 8, 32'h29), 36, 4, 32'h8);
    expData = put(expData, 60, 16, 32'h0);
    writeCfg(nc);
    waitFrame();
    t0 = accCyc;
    waitFrame();
    chk(93'(accCyc - t0), 93'(20 * TDIV));
    // ****************************************
    // Unused signal leaves its bits filled
    // ****************************************
    nc.sig[3].sigType = TYPE_OFF;
    nc.sig[0].cat = 3'h7;
    nc.sig[0].inst = 2'h3;
    nc.sig[0].minVal = -32'h0000_2710;
    expData = put(expData, 60, 4, 32'hF);
    expData = put(expData, 0, 16, 32'h0000_FFFB);
    writeCfg(nc);
    waitFrame();
    closeOut();
  end
endmodule // cptm_packer_tb
`default_nettype wire
